// File: core/wu_pkg.sv
// ==========================================================
// watch unit shared constants
// ==========================================================
package wu_pkg;
	// register offsets (byte addresses)
	localparam logic [7:0] WU_OFS_TIMER_CONTROL = 8'h60;
	localparam logic [7:0] WU_OFS_WRAP_MODE = 8'h64;
	localparam logic [7:0] WU_OFS_EVENT_CLEAR = 8'h6C;
	localparam logic [7:0] WU_OFS_EVENT_STATUS = 8'h70;
	localparam logic [7:0] WU_OFS_IRQ_ENABLE_SET = 8'h74;
	localparam logic [7:0] WU_OFS_IRQ_ENABLE_CLEAR = 8'h78;
	localparam logic [7:0] WU_OFS_IRQ_MASK_VIEW = 8'h7C;
	localparam logic [7:0] WU_OFS_SECONDS_COUNT = 8'h80;
	localparam logic [7:0] WU_OFS_ALARM_COMPARE = 8'h84;

	// timer_control command bits
	localparam int WU_BIT_SOFT_RESET_CMD = 0;
	localparam int WU_BIT_COUNTER_ON_CMD = 1;
	localparam int WU_BIT_COUNTER_OFF_CMD = 2;
	localparam int WU_BIT_ALARM_ENA_CMD = 3;
	localparam int WU_BIT_ALARM_DISARM_CMD = 4;

	// wrap_mode field
	localparam int WU_BIT_WRAP_SELECT = 0;

	// event flag positions (status, clear and mask share them)
	localparam int WU_EV_ALARM = 0;
	localparam int WU_EV_COUNTER_ON = 1;
	localparam int WU_EV_COUNTER_OFF = 2;
	localparam int WU_EV_ALARM_ON = 3;
	localparam int WU_EV_ALARM_OFF = 4;
	localparam int WU_EVENT_COUNT = 5;

	// live status positions
	localparam int WU_BIT_COUNT_WRITE_IN_PROGRESS = 5;
	localparam int WU_BIT_COUNTER_RUNNING_LEVEL = 8;
	localparam int WU_BIT_ALARM_ARMED_LEVEL = 9;

	// count limits
	localparam logic [31:0] WU_DAY_LAST = 32'hA8BFFFFF;
	localparam logic [31:0] WU_DAY_LIMIT = 32'hA8C00000;
	localparam logic [31:0] WU_COUNT_ZERO = 32'h00000000;

	// reset values
	localparam logic [31:0] WU_RST_SECONDS = 32'h00000000;
	localparam logic [31:0] WU_RST_ALARM = 32'h00000000;
	localparam logic WU_RST_WRAP = 1'b0;
	localparam logic [WU_EVENT_COUNT-1:0] WU_RST_MASK = 5'h00;
	localparam logic [31:0] WU_READ_ZERO = 32'h00000000;

	// nominal slow clock period, ns (tick comes from the pin)
	localparam real WU_SLOW_PERIOD_NS = 30518.0;
endpackage : wu_pkg

// File: core/wu_slow_edge.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// slow clock rising edge detector
// ==========================================================
module wu_slow_edge (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic slowClock,
	output logic slowTick
);
	// previous sample of the slow clock level
	logic slowPrev_r;

	// remember last level each system cycle
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			slowPrev_r <= 1'b0;
		end else begin
			slowPrev_r <= slowClock;
		end
	end

	// one system cycle pulse per slow period
	assign slowTick = slowClock & ~slowPrev_r;
endmodule : wu_slow_edge
`default_nettype wire

// File: core/wu_sticky_flag.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// sticky event flag, set beats clear
// ==========================================================
module wu_sticky_flag (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic soft_reset_cmd,
	input wire logic setPulse,
	input wire logic clrPulse,
	output logic flag
);
	// flag storage
	logic flag_r;

	// soft reset first, then set over clear
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			flag_r <= 1'b0;
		end else if (soft_reset_cmd) begin
			flag_r <= 1'b0;
		end else if (setPulse) begin
			flag_r <= 1'b1;
		end else if (clrPulse) begin
			flag_r <= 1'b0;
		end
	end

	assign flag = flag_r;
endmodule : wu_sticky_flag
`default_nettype wire

// File: core/wu_watch_timer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// watch unit: seconds counter with alarm
// ==========================================================
// Overview of operation
// (RULE1) soft reset bit restores all registers
// (RULE2) software waits slow clock settle after reset
// (RULE3) counter on/off commands; off wins
// (RULE4) alarm on/off commands; off wins
// (RULE5) wrap after day limit or full range
// (RULE6) write ones clear event flags 0..4
// (RULE7) alarm flag sticky until cleared
// (RULE8) flags 1..4 when command takes effect
// (RULE9) status bit 5 shows pending count write
// (RULE10) status bits 8,9 live enable levels
// (RULE11) mask bit gates each event onto irq
// (RULE12) seconds register counts, always readable
// (RULE13) count write only while counter stopped
// (RULE14) day mode drops out-of-range count write
// (RULE15) alarm write only while alarm disabled
// (RULE16) day mode drops out-of-range alarm write
// (RULE17) enabled alarm fires on count match
// (RULE18) counter advances once per slow period
// (RULE19) software waits for switch event
// (RULE20) alarm raised at end of matching period
// (RULE21) live count offered as frame time stamp
// (RULE22) enable-set and enable-clear shape mask
// (RULE23) slow-side events moved into bus domain
module wu_watch_timer
	import wu_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic slowClock,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [31:0] regRdData,
	output logic irqOut,
	output logic [31:0] stampCount
);

	// ==========================================================
	// slow tick
	// ==========================================================
	// one-cycle pulse at each rising slow clock edge
	logic slowTick;
	wu_slow_edge u_slow_edge (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.slowClock(slowClock),
		.slowTick(slowTick)
	);

	// ==========================================================
	// write decode
	// ==========================================================
	// per-register write strobes
	logic wrControl;
	logic wrMode;
	logic wrClear;
	logic wrMaskSet;
	logic wrMaskClr;
	logic wrSeconds;
	logic wrAlarm;
	// soft reset strobe
	logic soft_reset_cmd;
	// address decode of the write strobe
	always_comb begin
		wrControl = regWrEn && (regAddr == WU_OFS_TIMER_CONTROL);
		wrMode = regWrEn && (regAddr == WU_OFS_WRAP_MODE);
		wrClear = regWrEn && (regAddr == WU_OFS_EVENT_CLEAR);
		wrMaskSet = regWrEn && (regAddr == WU_OFS_IRQ_ENABLE_SET);
		wrMaskClr = regWrEn && (regAddr == WU_OFS_IRQ_ENABLE_CLEAR);
		wrSeconds = regWrEn && (regAddr == WU_OFS_SECONDS_COUNT);
		wrAlarm = regWrEn && (regAddr == WU_OFS_ALARM_COMPARE);
	end
	// zero in the bit is no effect
	assign soft_reset_cmd = wrControl && regWrData[WU_BIT_SOFT_RESET_CMD]; // RULE1

	// ==========================================================
	// mode register
	// ==========================================================
	// wrap select: 0 day mode, 1 full range
	logic wrapSelect_r;
	// plain read/write mode bit
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wrapSelect_r <= WU_RST_WRAP;
		end else if (soft_reset_cmd) begin
			wrapSelect_r <= WU_RST_WRAP; // RULE1
		end else if (wrMode) begin
			wrapSelect_r <= regWrData[WU_BIT_WRAP_SELECT];
		end
	end
	// day mode flag
	logic dayMode;
	assign dayMode = ~wrapSelect_r;

	// ==========================================================
	// enable commands, applied on the slow tick
	// ==========================================================
	// counter command waiting for the slow side
	logic cntCmdPend_r;
	// level the counter takes when the command lands
	logic cntCmdTarget_r;
	// alarm command waiting for the slow side
	logic almCmdPend_r;
	// level the alarm takes when the command lands
	logic almCmdTarget_r;
	// live levels
	logic counterRunningLevel_r;
	logic alarmArmedLevel_r;
	// capture counter command; disable beats enable
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cntCmdPend_r <= 1'b0;
			cntCmdTarget_r <= 1'b0;
		end else if (soft_reset_cmd) begin
			cntCmdPend_r <= 1'b0;
			cntCmdTarget_r <= 1'b0;
		end else if (wrControl && regWrData[WU_BIT_COUNTER_OFF_CMD]) begin
			cntCmdPend_r <= 1'b1; // RULE3
			cntCmdTarget_r <= 1'b0; // RULE3
		end else if (wrControl && regWrData[WU_BIT_COUNTER_ON_CMD]) begin
			cntCmdPend_r <= 1'b1; // RULE3
			cntCmdTarget_r <= 1'b1; // RULE3
		end else if (slowTick) begin
			// command consumed by the slow side
			cntCmdPend_r <= 1'b0;
		end
	end
	// capture alarm command; disable beats enable
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			almCmdPend_r <= 1'b0;
			almCmdTarget_r <= 1'b0;
		end else if (soft_reset_cmd) begin
			almCmdPend_r <= 1'b0;
			almCmdTarget_r <= 1'b0;
		end else if (wrControl && regWrData[WU_BIT_ALARM_DISARM_CMD]) begin
			almCmdPend_r <= 1'b1; // RULE4
			almCmdTarget_r <= 1'b0; // RULE4
		end else if (wrControl && regWrData[WU_BIT_ALARM_ENA_CMD]) begin
			almCmdPend_r <= 1'b1; // RULE4
			almCmdTarget_r <= 1'b1; // RULE4
		end else if (slowTick) begin
			// command consumed by the slow side
			almCmdPend_r <= 1'b0;
		end
	end
	// commands that land on this tick
	logic cntCmdLand;
	logic almCmdLand;
	assign cntCmdLand = slowTick && cntCmdPend_r;
	assign almCmdLand = slowTick && almCmdPend_r;
	// live enable levels change only on a tick or a soft reset
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			counterRunningLevel_r <= 1'b0;
			alarmArmedLevel_r <= 1'b0;
		end else if (soft_reset_cmd) begin
			counterRunningLevel_r <= 1'b0;
			alarmArmedLevel_r <= 1'b0;
		end else begin
			if (cntCmdLand) begin
				counterRunningLevel_r <= cntCmdTarget_r; // RULE3
			end
			if (almCmdLand) begin
				alarmArmedLevel_r <= almCmdTarget_r; // RULE4
			end
		end
	end

	// ==========================================================
	// seconds count
	// ==========================================================
	// live seconds count
	logic [31:0] secondsCount_r;
	logic [31:0] secondsCount_nxt;
	// accepted value waiting to be loaded on a tick
	logic [31:0] countLoad_r;
	logic countWriteInProgress_r;
	// range check for day mode
	logic secondsWrOk;
	logic alarmWrOk;
	// refuse while running or out of day range
	assign secondsWrOk = wrSeconds && !counterRunningLevel_r // RULE13
		&& !(dayMode && (regWrData >= WU_DAY_LIMIT)); // RULE14
	// refuse while alarm enabled or out of day range
	assign alarmWrOk = wrAlarm && !alarmArmedLevel_r // RULE15
		&& !(dayMode && (regWrData >= WU_DAY_LIMIT)); // RULE16
	// hold an accepted count until the next tick
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			countLoad_r <= WU_RST_SECONDS;
			countWriteInProgress_r <= 1'b0;
		end else if (soft_reset_cmd) begin
			countLoad_r <= WU_RST_SECONDS;
			countWriteInProgress_r <= 1'b0;
		end else if (secondsWrOk) begin
			countLoad_r <= regWrData;
			countWriteInProgress_r <= 1'b1; // RULE9
		end else if (slowTick) begin
			countWriteInProgress_r <= 1'b0; // RULE9
		end
	end
	// next count: load, advance with wrap, or hold
	always_comb begin
		secondsCount_nxt = secondsCount_r;
		if (slowTick) begin
			if (countWriteInProgress_r) begin
				// pending write lands at the slow edge
				secondsCount_nxt = countLoad_r;
			end else if (counterRunningLevel_r) begin
				if (dayMode && (secondsCount_r >= WU_DAY_LAST)) begin
					secondsCount_nxt = WU_COUNT_ZERO; // RULE5
				end else begin
					// full range wraps naturally
					secondsCount_nxt = secondsCount_r + 32'h00000001; // RULE18
				end
			end
		end
	end
	// count register
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			secondsCount_r <= WU_RST_SECONDS;
		end else if (soft_reset_cmd) begin
			secondsCount_r <= WU_RST_SECONDS; // RULE1
		end else begin
			secondsCount_r <= secondsCount_nxt; // RULE12
		end
	end
	// time stamp for frame controllers
	assign stampCount = secondsCount_r; // RULE21

	// ==========================================================
	// alarm compare
	// ==========================================================
	// compare value
	logic [31:0] alarmValue_r;
	// match seen as the period ends
	logic alarmHit;
	// compare register write
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			alarmValue_r <= WU_RST_ALARM;
		end else if (soft_reset_cmd) begin
			alarmValue_r <= WU_RST_ALARM; // RULE1
		end else if (alarmWrOk) begin
			alarmValue_r <= regWrData; // RULE15
		end
	end
	// period with equal value is ending at this tick
	assign alarmHit = slowTick && alarmArmedLevel_r // RULE17
		&& (secondsCount_r == alarmValue_r); // RULE20

	// ==========================================================
	// event flags
	// ==========================================================
	// set and clear pulses per event
	logic [WU_EVENT_COUNT-1:0] evSet;
	logic [WU_EVENT_COUNT-1:0] evClr;
	logic [WU_EVENT_COUNT-1:0] evFlag;
	// slow-side events arrive as system-cycle pulses
	always_comb begin
		evSet = '0;
		evSet[WU_EV_ALARM] = alarmHit; // RULE7
		evSet[WU_EV_COUNTER_ON] = cntCmdLand && cntCmdTarget_r; // RULE8
		evSet[WU_EV_COUNTER_OFF] = cntCmdLand && !cntCmdTarget_r; // RULE8
		evSet[WU_EV_ALARM_ON] = almCmdLand && almCmdTarget_r; // RULE8
		evSet[WU_EV_ALARM_OFF] = almCmdLand && !almCmdTarget_r; // RULE8
	end
	// ones in the clear word clear matching flags
	assign evClr = wrClear ? regWrData[WU_EVENT_COUNT-1:0] // RULE6
		: '0;
	// one sticky flag per event source
	genvar gi;
	generate
		for (gi = 0; gi < WU_EVENT_COUNT; gi++) begin : g_flag
			wu_sticky_flag u_flag (
				.clk_sys(clk_sys),
				.rst_b(rst_b),
				.soft_reset_cmd(soft_reset_cmd),
				.setPulse(evSet[gi]),
				.clrPulse(evClr[gi]),
				.flag(evFlag[gi])
			); // RULE23
		end
	endgenerate
	// ==========================================================
	// interrupt mask
	// ==========================================================
	// mask bits, one per event
	logic [WU_EVENT_COUNT-1:0] irqMask_r;
	// ones set via enable-set, clear via enable-clear
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irqMask_r <= WU_RST_MASK;
		end else if (soft_reset_cmd) begin
			irqMask_r <= WU_RST_MASK; // RULE1
		end else if (wrMaskSet) begin
			irqMask_r <= irqMask_r | regWrData[WU_EVENT_COUNT-1:0]; // RULE22
		end else if (wrMaskClr) begin
			irqMask_r <= irqMask_r & ~regWrData[WU_EVENT_COUNT-1:0]; // RULE22
		end
	end
	// masked-off sources never reach the output
	assign irqOut = |(evFlag & irqMask_r); // RULE11
	// ==========================================================
	// read path
	// ==========================================================
	// assembled status word
	logic [31:0] statusWord;
	// read data, valid the cycle after the strobe
	logic [31:0] regRdData_r;
	logic [31:0] regRdData_nxt;
	// status layout: flags, busy, live levels
	always_comb begin
		statusWord = WU_READ_ZERO;
		statusWord[WU_EVENT_COUNT-1:0] = evFlag;
		statusWord[WU_BIT_COUNT_WRITE_IN_PROGRESS] =
			countWriteInProgress_r; // RULE9
		statusWord[WU_BIT_COUNTER_RUNNING_LEVEL] =
			counterRunningLevel_r; // RULE10
		statusWord[WU_BIT_ALARM_ARMED_LEVEL] =
			alarmArmedLevel_r; // RULE10
	end
	// write-only and unmapped offsets read zero
	always_comb begin
		regRdData_nxt = WU_READ_ZERO;
		if (regRdEn) begin
			case (regAddr)
				WU_OFS_WRAP_MODE: begin
					regRdData_nxt[WU_BIT_WRAP_SELECT] = wrapSelect_r;
				end
				WU_OFS_EVENT_STATUS: begin
					regRdData_nxt = statusWord;
				end
				WU_OFS_IRQ_MASK_VIEW: begin
					regRdData_nxt[WU_EVENT_COUNT-1:0] = irqMask_r; // RULE11
				end
				WU_OFS_SECONDS_COUNT: begin
					regRdData_nxt = secondsCount_r; // RULE12
				end
				WU_OFS_ALARM_COMPARE: begin
					regRdData_nxt = alarmValue_r;
				end
				default: begin
					regRdData_nxt = WU_READ_ZERO;
				end
			endcase
		end
	end
	// read data register, zero outside the answer cycle
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			regRdData_r <= WU_READ_ZERO;
		end else begin
			regRdData_r <= regRdData_nxt;
		end
	end
	assign regRdData = regRdData_r;
endmodule : wu_watch_timer
`default_nettype wire

// File: tb/wu_watch_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker for the watch unit
// ==========================================================
module wu_watch_timer_chk (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic slowClock,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [31:0] regRdData,
	input wire logic irqOut,
	input wire logic [31:0] stampCount
);
	// soft reset request on the bus
	logic swReq;
	assign swReq = regWrEn && regAddr == 8'h60 && regWrData[0];
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	rd_idle_zero_a: assert property (
		!$past(regRdEn) |-> regRdData == 32'h00000000)
		else $error("read data not zero outside read slot");
	wo_read_zero_a: assert property (
		$past(regRdEn && regAddr inside {8'h60, 8'h6C, 8'h74, 8'h78})
		|-> regRdData == 32'h00000000)
		else $error("write-only register read not zero");
	count_read_a: assert property (
		$past(regRdEn && regAddr == 8'h80) |-> regRdData == $past(stampCount))
		else $error("count read differs from stamp");
	status_rsvd_a: assert property (
		$past(regRdEn && regAddr == 8'h70)
		|-> regRdData[31:10] == 22'h00000 && regRdData[7:6] == 2'h0)
		else $error("status reserved bits set");
	mask_rsvd_a: assert property (
		$past(regRdEn && regAddr == 8'h7C) |-> regRdData[31:5] == 27'h000000)
		else $error("mask reserved bits set");
	soft_reset_a: assert property (
		swReq |=> (stampCount == 32'h00000000 && !irqOut) [*2])
		else $error("soft reset did not clear");
	count_step_a: assert property (
		$changed(stampCount)
		|-> ($past(slowClock) && !$past(slowClock, 2)) || $past(swReq))
		else $error("count moved without a tick");
	irq_rise_a: assert property (
		$rose(irqOut) |-> ($past(slowClock) && !$past(slowClock, 2))
		|| $past(regWrEn && regAddr == 8'h74))
		else $error("irq rose without cause");
	irq_fall_a: assert property (
		$fell(irqOut)
		|-> $past(regWrEn && regAddr inside {8'h60, 8'h6C, 8'h78}))
		else $error("irq fell without clear");
endmodule : wu_watch_timer_chk
`default_nettype wire

// File: tb/wu_watch_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// self-checking bench for the watch unit
// ==========================================================
module wu_watch_timer_test;
	logic clk_sys;
	logic rst_b;
	logic slowClock;
	logic [7:0] regAddr;
	logic [31:0] regWrData;
	logic regWrEn;
	logic regRdEn;
	logic [31:0] regRdData;
	logic irqOut;
	logic [31:0] stampCount;
	int n_mismatch;
	int checked;
	int cycles;
	wu_watch_timer uut (.clk_sys(clk_sys), .rst_b(rst_b),
		.slowClock(slowClock), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
		.irqOut(irqOut), .stampCount(stampCount));
	// 200 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// ==========================================================
	// bus and tick helpers
	// ==========================================================
	task cmp(input logic [31:0] got, input logic [31:0] e);
		checked++;
		if (got !== e) begin
			n_mismatch++;
			$display("ERROR %0t: got %h want %h", $time, got, e);
		end
	endtask : cmp
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= v;
		regWrEn <= 1'b1;
		@(posedge clk_sys);
		regWrEn <= 1'b0;
		// let the edge's register updates settle before any compare
		#1;
	endtask : wr
	task rdx(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clk_sys);
		regRdEn <= 1'b0;
		#1;
		cmp(regRdData, e);
	endtask : rdx
	// one slow clock pulse per tick, slow low between pulses
	task ticks(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			slowClock <= 1'b1;
			repeat (2) @(posedge clk_sys);
			slowClock <= 1'b0;
			repeat (2) @(posedge clk_sys);
		end
	endtask : ticks
	// ==========================================================
	// scenarios
	// ==========================================================
	// every register reads zero, unmapped too
	task t_reset_vals;
		logic [7:0] adr[10];
		adr = '{8'h60, 8'h64, 8'h68, 8'h6C, 8'h70, 8'h74, 8'h78, 8'h7C,
			8'h80, 8'h84};
		foreach (adr[i]) rdx(adr[i], 32'h00000000);
		cmp({31'h0, irqOut}, 32'h00000000);
	endtask : t_reset_vals
	// mask set and clear registers
	task t_mask;
		wr(8'h74, 32'h0000001F);
		rdx(8'h7C, 32'h0000001F);
		wr(8'h78, 32'h00000005);
		rdx(8'h7C, 32'h0000001A);
		wr(8'h78, 32'h0000001F);
		rdx(8'h7C, 32'h00000000);
	endtask : t_mask
	// counter start, count, refused load, stop with both bits
	task t_counter;
		wr(8'h74, 32'h00000002);
		wr(8'h60, 32'h00000002);
		rdx(8'h70, 32'h00000000);
		ticks(1);
		rdx(8'h70, 32'h00000102);
		cmp({31'h0, irqOut}, 32'h00000001);
		ticks(3);
		rdx(8'h80, 32'h00000003);
		cmp(stampCount, 32'h00000003);
		wr(8'h80, 32'h00000055);
		ticks(1);
		rdx(8'h80, 32'h00000004);
		wr(8'h6C, 32'h00000002);
		cmp({31'h0, irqOut}, 32'h00000000);
		rdx(8'h70, 32'h00000100);
		wr(8'h60, 32'h00000006);
		ticks(1);
		rdx(8'h70, 32'h00000004);
		ticks(2);
		rdx(8'h80, 32'h00000005);
	endtask : t_counter
	// range filter, pending load and both wrap modes
	task t_wrap;
		wr(8'h60, 32'h00000001);
		ticks(4);
		wr(8'h80, 32'hA8C00000);
		ticks(1);
		rdx(8'h80, 32'h00000000);
		wr(8'h80, 32'hA8BFFFFE);
		rdx(8'h70, 32'h00000020);
		ticks(1);
		rdx(8'h70, 32'h00000000);
		wr(8'h60, 32'h00000002);
		ticks(2);
		rdx(8'h80, 32'hA8BFFFFF);
		ticks(1);
		rdx(8'h80, 32'h00000000);
		wr(8'h60, 32'h00000004);
		wr(8'h64, 32'h00000001);
		rdx(8'h64, 32'h00000001);
		ticks(1);
		wr(8'h80, 32'hFFFFFFFF);
		ticks(1);
		rdx(8'h80, 32'hFFFFFFFF);
		wr(8'h60, 32'h00000002);
		ticks(2);
		rdx(8'h80, 32'h00000000);
	endtask : t_wrap
	// alarm match timing, sticky flag, disarm, soft reset
	task t_alarm;
		wr(8'h60, 32'h00000001);
		ticks(4);
		wr(8'h84, 32'hA8C00000);
		rdx(8'h84, 32'h00000000);
		wr(8'h84, 32'h00000003);
		wr(8'h74, 32'h00000001);
		wr(8'h60, 32'h0000000A);
		ticks(1);
		rdx(8'h70, 32'h0000030A);
		wr(8'h84, 32'h00000007);
		rdx(8'h84, 32'h00000003);
		ticks(3);
		cmp({31'h0, irqOut}, 32'h00000000);
		ticks(1);
		cmp({31'h0, irqOut}, 32'h00000001);
		ticks(1);
		rdx(8'h70, 32'h0000030B);
		wr(8'h6C, 32'h00000001);
		cmp({31'h0, irqOut}, 32'h00000000);
		wr(8'h60, 32'h00000018);
		ticks(1);
		rdx(8'h70, 32'h0000011A);
		wr(8'h60, 32'h00000003);
		ticks(4);
		t_reset_vals();
	endtask : t_alarm
	// ==========================================================
	// verdict and hang guard
	// ==========================================================
	task wrap_up;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up
	// cycle ceiling well above the expected run
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			$display("ERROR %0t: timeout", $time);
			wrap_up();
		end
	end
	// main sequence
	initial begin
		rst_b = 1'b0;
		slowClock = 1'b0;
		regAddr = 8'h00;
		regWrData = 32'h00000000;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_reset_vals();
		t_mask();
		t_counter();
		t_wrap();
		t_alarm();
		wrap_up();
	end
endmodule : wu_watch_timer_test
bind wu_watch_timer wu_watch_timer_chk chk (.clk_sys(clk_sys),
	.rst_b(rst_b), .slowClock(slowClock), .regAddr(regAddr),
	.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
	.regRdData(regRdData), .irqOut(irqOut), .stampCount(stampCount));
`default_nettype wire
